// file: cpu_regs_params.svh
// constants for the cpu register set: register indices, flag bit positions
// assumes: included by bare name from the flag unit, the register file, the monitor and the bench
`ifndef CPU_REGS_PARAMS_SVH
`define CPU_REGS_PARAMS_SVH

// register indices on the plain software port (word per index)
`define IDX_GP_DATA_0 4'h0
`define IDX_GP_DATA_1 4'h1
`define IDX_GP_DATA_2 4'h2
`define IDX_GP_DATA_3 4'h3
`define IDX_ADDR_PTR_0 4'h4
`define IDX_ADDR_PTR_1 4'h5
`define IDX_FRAME_BASE 4'h6
`define IDX_VECTOR_TABLE_BASE 4'h7
`define IDX_NEXT_INSTR_ADDR 4'h8
`define IDX_USER_STACK_PTR 4'h9
`define IDX_IRQ_STACK_PTR 4'hA
`define IDX_STATIC_BASE 4'hB
`define IDX_CPU_FLAGS 4'hC
`define IDX_ACTIVE_SP 4'hD

// flag register bit positions
`define FLG_CARRY 0
`define FLG_TRACE 1
`define FLG_ZERO 2
`define FLG_SIGN 3
`define FLG_BANK 4
`define FLG_WRAP 5
`define FLG_IEN 6
`define FLG_STACK 7
`define FLG_IPL_LO 8
`define FLG_IPL_HI 10

// flag reset value: all 11 bits are live in this implementation
`define FLG_RESET 11'h000
`define TRAP_LAST 6'h1F
`define SEL_HIGH 2'h2
`define SEL_LOW 2'h1
`define SEL_WORD 2'h0

`endif

// file: cpu_regs_pkg.sv
// types for the cpu register set
// assumes: nothing beyond the params header
package cpu_regs_pkg;
    // byte lane selection of a data register write
    typedef enum logic [1:0] {
        lane_word = 2'b00,
        lane_low = 2'b01,
        lane_high = 2'b10
    } lane_sel_t;
endpackage

// file: cpu_flag_unit.sv
// condition flag and interrupt gate logic for the cpu flag register
// assumes: same clock as the register file; inputs come from the datapath and the software port
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_params.svh"
module cpu_flag_unit
    import cpu_regs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sw_wr,
    input wire logic [10:0] sw_wdata,
    input wire logic alu_done,
    input wire logic alu_carry,
    input wire logic alu_zero,
    input wire logic alu_neg,
    input wire logic alu_ovf,
    input wire logic hw_irq_ack,
    input wire logic sw_trap_ack,
    input wire logic [5:0] sw_trap_num,
    input wire logic [2:0] irq_req_level,
    output logic [10:0] flags_q,
    output logic irq_accept
);
    logic [10:0] flags_d;
    wire logic low_trap = sw_trap_ack && (sw_trap_num <= `TRAP_LAST);

    // ========================================
    // next flag value
    // software write first, then alu result, then acknowledge side effects
    always_comb begin
        flags_d = flags_q;
        if (sw_wr) begin
            flags_d = sw_wdata;
        end
        if (alu_done) begin // end of instruction, visible next
            flags_d[`FLG_CARRY] = alu_carry;
            flags_d[`FLG_ZERO] = alu_zero;
            flags_d[`FLG_SIGN] = alu_neg;
            flags_d[`FLG_WRAP] = alu_ovf;
        end
        if (hw_irq_ack || sw_trap_ack) begin
            flags_d[`FLG_IEN] = 1'b0;
        end
        if (hw_irq_ack || low_trap) begin
            flags_d[`FLG_STACK] = 1'b0;
        end
    end

    // flag storage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_q <= `FLG_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // maskable request accepted only when gated on and above the level
    assign irq_accept = flags_q[`FLG_IEN]
        && (irq_req_level > flags_q[`FLG_IPL_HI:`FLG_IPL_LO]);
endmodule // cpu_flag_unit
`default_nettype wire

// file: cpu_register_set.sv
// cpu core register set: data, address, base, pc, stack pointers and flags
// assumes: one core clock; datapath and software port in the same domain
//
// Overview of operation
// - four 16-bit general data registers
// - data registers split into 8-bit halves
// - third/first and fourth/second pair to 32
// - two address registers, pairable to 32 bits
// - 16-bit frame base register
// - 20-bit vector table base register
// - 20-bit program counter, next instruction
// - user and interrupt stack pointers, select bit
// - interrupt or low trap clears stack select
// - 16-bit static base register
// - flag register is 11 bits
// - carry flag captures carry, borrow, shift-out
// - zero flag set on zero result
// - sign flag set on negative result
// - bank bit picks register bank 0 or 1
// - overflow flag set on overflow
// - interrupt gate blocks maskable interrupts when 0
// - any acknowledge clears interrupt gate
// - 3-bit level, accept only higher priority
// - reserved bits write 0, read any
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_params.svh"
module cpu_register_set
    import cpu_regs_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int WIDE_W = 20
) (
    input wire logic core_clk,
    input wire logic rst,
    // software register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // datapath write ports for data, address, pc and stack pointer registers
    input wire logic dp_data_wr,
    input wire logic [1:0] dp_data_idx,
    input wire lane_sel_t dp_data_lane,
    input wire logic [DATA_W-1:0] dp_data_val,
    input wire logic dp_wide_wr,
    input wire logic dp_wide_hi,
    input wire logic [2*DATA_W-1:0] dp_wide_val,
    input wire logic dp_addr_wr,
    input wire logic dp_addr_idx,
    input wire logic [DATA_W-1:0] dp_addr_val,
    input wire logic dp_addr_pair_wr,
    input wire logic [2*DATA_W-1:0] dp_addr_pair_val,
    input wire logic dp_pc_wr,
    input wire logic [WIDE_W-1:0] dp_pc_val,
    input wire logic dp_sp_wr,
    input wire logic [DATA_W-1:0] dp_sp_val,
    // flag sources
    input wire logic alu_done,
    input wire logic alu_carry,
    input wire logic alu_zero,
    input wire logic alu_neg,
    input wire logic alu_ovf,
    input wire logic hw_irq_ack,
    input wire logic sw_trap_ack,
    input wire logic [5:0] sw_trap_num,
    input wire logic [2:0] irq_req_level,
    // views toward the datapath
    output logic [1:0] dp_rd_idx_unused_low,
    output logic [2*DATA_W-1:0] wide_data_lo_pair,
    output logic [2*DATA_W-1:0] wide_data_hi_pair,
    output logic [2*DATA_W-1:0] wide_addr_pair,
    output logic [7:0] gp_data_0_high,
    output logic [7:0] gp_data_0_low,
    output logic [DATA_W-1:0] active_stack_ptr,
    output logic [DATA_W-1:0] frame_base,
    output logic [DATA_W-1:0] static_base,
    output logic [WIDE_W-1:0] vector_table_base,
    output logic [WIDE_W-1:0] next_instr_addr,
    output logic [10:0] cpu_flags,
    output logic regset_select,
    output logic irq_accept
);
    // ========================================
    // storage: two banks of four data registers and two address registers
    logic [DATA_W-1:0] gp_q [2][4];
    logic [DATA_W-1:0] ap_q [2][2];
    logic [DATA_W-1:0] frame_base_q;
    logic [DATA_W-1:0] static_base_q;
    logic [DATA_W-1:0] user_sp_q;
    logic [DATA_W-1:0] irq_sp_q;
    logic [WIDE_W-1:0] vtb_q;
    logic [WIDE_W-1:0] pc_q;
    logic [31:0] rdata_q;
    logic [10:0] flags_q;

    // ========================================
    // decode of the software port
    wire logic bank = flags_q[`FLG_BANK];
    wire logic use_user_sp = flags_q[`FLG_STACK];
    wire logic sw_gp = reg_wr && (reg_addr <= `IDX_GP_DATA_3);
    wire logic sw_ap0 = reg_wr && (reg_addr == `IDX_ADDR_PTR_0);
    wire logic sw_ap1 = reg_wr && (reg_addr == `IDX_ADDR_PTR_1);
    wire logic sw_fb = reg_wr && (reg_addr == `IDX_FRAME_BASE);
    wire logic sw_vtb = reg_wr && (reg_addr == `IDX_VECTOR_TABLE_BASE);
    wire logic sw_pc = reg_wr && (reg_addr == `IDX_NEXT_INSTR_ADDR);
    wire logic sw_usp = reg_wr && (reg_addr == `IDX_USER_STACK_PTR);
    wire logic sw_isp = reg_wr && (reg_addr == `IDX_IRQ_STACK_PTR);
    wire logic sw_sb = reg_wr && (reg_addr == `IDX_STATIC_BASE);
    wire logic sw_flg = reg_wr && (reg_addr == `IDX_CPU_FLAGS);
    // datapath stack write goes to whichever pointer is selected
    wire logic dp_usp = dp_sp_wr && use_user_sp;
    wire logic dp_isp = dp_sp_wr && !use_user_sp;

    // ========================================
    // data registers: per register, word, byte or pair write
    // datapath wins over software so an instruction result is never lost
    generate
        for (genvar i = 0; i < 4; i++) begin : g_gp
            wire logic dp_hit = dp_data_wr && (dp_data_idx == 2'(i));
            // pair low word lands in gp0/gp1, high word in gp2/gp3
            wire logic wide_hit = dp_wide_wr && (dp_wide_hi == 1'(i % 2));
            wire logic [DATA_W-1:0] wide_word =
                (i >= 2) ? dp_wide_val[2*DATA_W-1:DATA_W] : dp_wide_val[DATA_W-1:0];
            logic [DATA_W-1:0] nxt;
            always_comb begin
                nxt = gp_q[bank][i];
                if (sw_gp && (reg_addr[1:0] == 2'(i))) begin
                    nxt = reg_wdata[DATA_W-1:0];
                end
                if (wide_hit) begin
                    nxt = wide_word;
                end else if (dp_hit) begin
                    case (dp_data_lane)
                        lane_low: nxt[7:0] = dp_data_val[7:0];
                        lane_high: nxt[15:8] = dp_data_val[7:0];
                        default: nxt = dp_data_val;
                    endcase
                end
            end
            // only the selected bank is written; constant bank indices keep each
            // element owned by exactly one process across the generate copies
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    gp_q[0][i] <= '0;
                    gp_q[1][i] <= '0;
                end else if (bank) begin
                    gp_q[1][i] <= nxt;
                end else begin
                    gp_q[0][i] <= nxt;
                end
            end
        end
    endgenerate

    // ========================================
    // address registers, single or as one 32-bit pair
    logic [DATA_W-1:0] ap0_d;
    logic [DATA_W-1:0] ap1_d;
    always_comb begin
        ap0_d = sw_ap0 ? reg_wdata[DATA_W-1:0] : ap_q[bank][0];
        ap1_d = sw_ap1 ? reg_wdata[DATA_W-1:0] : ap_q[bank][1];
        if (dp_addr_pair_wr) begin
            ap0_d = dp_addr_pair_val[DATA_W-1:0];
            ap1_d = dp_addr_pair_val[2*DATA_W-1:DATA_W];
        end else if (dp_addr_wr && !dp_addr_idx) begin
            ap0_d = dp_addr_val;
        end else if (dp_addr_wr && dp_addr_idx) begin
            ap1_d = dp_addr_val;
        end
    end

    // address register storage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ap_q[0][0] <= '0;
            ap_q[0][1] <= '0;
            ap_q[1][0] <= '0;
            ap_q[1][1] <= '0;
        end else begin
            ap_q[bank][0] <= ap0_d;
            ap_q[bank][1] <= ap1_d;
        end
    end

    // ========================================
    // base registers, pc and stack pointers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            frame_base_q <= '0;
            static_base_q <= '0;
            vtb_q <= '0;
            pc_q <= '0;
            user_sp_q <= '0;
            irq_sp_q <= '0;
        end else begin
            if (sw_fb) frame_base_q <= reg_wdata[DATA_W-1:0];
            if (sw_sb) static_base_q <= reg_wdata[DATA_W-1:0];
            if (sw_vtb) vtb_q <= reg_wdata[WIDE_W-1:0];
            if (dp_pc_wr) pc_q <= dp_pc_val;
            else if (sw_pc) pc_q <= reg_wdata[WIDE_W-1:0];
            if (dp_usp) user_sp_q <= dp_sp_val;
            else if (sw_usp) user_sp_q <= reg_wdata[DATA_W-1:0];
            if (dp_isp) irq_sp_q <= dp_sp_val;
            else if (sw_isp) irq_sp_q <= reg_wdata[DATA_W-1:0];
        end
    end

    // ========================================
    // flag register and interrupt gating
    // trace bit is stored as written; software is expected to keep it 0
    cpu_flag_unit u_flags (
        .core_clk(core_clk),
        .rst(rst),
        .sw_wr(sw_flg),
        .sw_wdata(reg_wdata[10:0]),
        .alu_done(alu_done),
        .alu_carry(alu_carry),
        .alu_zero(alu_zero),
        .alu_neg(alu_neg),
        .alu_ovf(alu_ovf),
        .hw_irq_ack(hw_irq_ack),
        .sw_trap_ack(sw_trap_ack),
        .sw_trap_num(sw_trap_num),
        .irq_req_level(irq_req_level),
        .flags_q(flags_q),
        .irq_accept(irq_accept)
    );

    // ========================================
    // read mux, data one cycle after the read strobe
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (reg_addr <= `IDX_GP_DATA_3) rd_mux[DATA_W-1:0] = gp_q[bank][reg_addr[1:0]];
        else if (reg_addr == `IDX_ADDR_PTR_0) rd_mux[DATA_W-1:0] = ap_q[bank][0];
        else if (reg_addr == `IDX_ADDR_PTR_1) rd_mux[DATA_W-1:0] = ap_q[bank][1];
        else if (reg_addr == `IDX_FRAME_BASE) rd_mux[DATA_W-1:0] = frame_base_q;
        else if (reg_addr == `IDX_VECTOR_TABLE_BASE) rd_mux[WIDE_W-1:0] = vtb_q;
        else if (reg_addr == `IDX_NEXT_INSTR_ADDR) rd_mux[WIDE_W-1:0] = pc_q;
        else if (reg_addr == `IDX_USER_STACK_PTR) rd_mux[DATA_W-1:0] = user_sp_q;
        else if (reg_addr == `IDX_IRQ_STACK_PTR) rd_mux[DATA_W-1:0] = irq_sp_q;
        else if (reg_addr == `IDX_STATIC_BASE) rd_mux[DATA_W-1:0] = static_base_q;
        else if (reg_addr == `IDX_CPU_FLAGS) rd_mux[10:0] = flags_q;
        else if (reg_addr == `IDX_ACTIVE_SP) rd_mux[DATA_W-1:0] = active_stack_ptr;
    end

    // read data register; unmapped indices return zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end
    end

    // ========================================
    // views toward the datapath
    assign reg_rdata = rdata_q;
    assign wide_data_lo_pair = {gp_q[bank][2], gp_q[bank][0]};
    assign wide_data_hi_pair = {gp_q[bank][3], gp_q[bank][1]};
    assign wide_addr_pair = {ap_q[bank][1], ap_q[bank][0]};
    assign gp_data_0_high = gp_q[bank][0][15:8];
    assign gp_data_0_low = gp_q[bank][0][7:0];
    assign active_stack_ptr = use_user_sp ? user_sp_q : irq_sp_q;
    assign frame_base = frame_base_q;
    assign static_base = static_base_q;
    assign vector_table_base = vtb_q;
    assign next_instr_addr = pc_q;
    assign cpu_flags = flags_q;
    assign regset_select = bank;
    assign dp_rd_idx_unused_low = 2'h0;
endmodule // cpu_register_set
`default_nettype wire

// file: dp_partner.sv
// datapath and interrupt acceptance partner for the cpu register set
// assumes: shares core_clk and rst with the register set
`timescale 1ns/1ps
`default_nettype none
module dp_partner (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [15:0] op_a,
    input wire logic [15:0] op_b,
    input wire logic irq_pending,
    input wire logic irq_accept,
    output logic alu_done,
    output logic alu_carry,
    output logic alu_zero,
    output logic alu_neg,
    output logic alu_ovf,
    output logic hw_irq_ack
);
    // ==========================================================================
    // adder with carry out on top
    wire logic [16:0] sum = {1'h0, op_a} + {1'h0, op_b};
    wire logic wrap = (op_a[15] == op_b[15]) && (sum[15] != op_a[15]);
    // one-cycle result strobe; ack only once the core agrees to take the request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {alu_done, alu_carry, alu_zero, alu_neg, alu_ovf, hw_irq_ack} <= 6'h00;
        end else begin
            alu_done <= go;
            {alu_carry, alu_zero, alu_neg, alu_ovf} <= {sum[16], sum[15:0] == 16'h0000, sum[15], wrap};
            hw_irq_ack <= irq_pending & irq_accept & ~hw_irq_ack;
        end
    end
endmodule // dp_partner
`default_nettype wire

// file: cpu_register_set_monitor.sv
// checker for the cpu register set: flag, read and interrupt relations
// assumes: bound to cpu_register_set; one clock, rst async active high
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_params.svh"
module cpu_register_set_monitor (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic alu_done,
    input wire logic alu_carry,
    input wire logic alu_zero,
    input wire logic alu_neg,
    input wire logic alu_ovf,
    input wire logic hw_irq_ack,
    input wire logic sw_trap_ack,
    input wire logic [5:0] sw_trap_num,
    input wire logic [2:0] irq_req_level,
    input wire logic [10:0] cpu_flags,
    input wire logic regset_select,
    input wire logic irq_accept
);
    // ==========================================================================
    // one clock; nothing is judged while reset is applied
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // first steps of a flag read, an acknowledge and a high trap
    sequence flag_rd_s;
        reg_rd && reg_addr == `IDX_CPU_FLAGS;
    endsequence
    sequence any_ack_s;
        hw_irq_ack || sw_trap_ack;
    endsequence
    sequence high_trap_s;
        sw_trap_ack && sw_trap_num > `TRAP_LAST && !hw_irq_ack
            && !(reg_wr && reg_addr == `IDX_CPU_FLAGS);
    endsequence
    rd_flags_a: assert property (flag_rd_s |=>
        reg_rdata == {21'h000000, $past(cpu_flags)}) else $error("flag read data wrong");
    carry_capture_a: assert property (alu_done |=>
        cpu_flags[`FLG_CARRY] == $past(alu_carry)) else $error("carry flag not captured");
    result_flags_a: assert property (alu_done |=>
        cpu_flags[`FLG_ZERO] == $past(alu_zero) && cpu_flags[`FLG_SIGN] == $past(alu_neg)
        && cpu_flags[`FLG_WRAP] == $past(alu_ovf)) else $error("result flags wrong");
    gate_clear_a: assert property (any_ack_s |=> !cpu_flags[`FLG_IEN])
        else $error("gate left open after ack");
    stack_clear_a: assert property (
        hw_irq_ack || (sw_trap_ack && sw_trap_num <= `TRAP_LAST) |=> !cpu_flags[`FLG_STACK])
        else $error("stack select not cleared");
    stack_keep_a: assert property (high_trap_s |=> $stable(cpu_flags[`FLG_STACK]))
        else $error("high trap changed stack select");
    irq_accept_a: assert property (
        irq_accept == (cpu_flags[`FLG_IEN] && irq_req_level > cpu_flags[10:8]))
        else $error("interrupt acceptance wrong");
    bank_view_a: assert property (regset_select == cpu_flags[`FLG_BANK])
        else $error("bank select output wrong");
endmodule // cpu_register_set_monitor
bind cpu_register_set cpu_register_set_monitor u_monitor (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .alu_done(alu_done), .alu_carry(alu_carry), .alu_zero(alu_zero),
    .alu_neg(alu_neg), .alu_ovf(alu_ovf), .hw_irq_ack(hw_irq_ack), .sw_trap_ack(sw_trap_ack),
    .sw_trap_num(sw_trap_num), .irq_req_level(irq_req_level), .cpu_flags(cpu_flags),
    .regset_select(regset_select), .irq_accept(irq_accept));
`default_nettype wire

// file: cpu_register_set_and_flags_tb.sv
// self-checking bench for the cpu register set with a datapath partner
// assumes: design, partner and monitor compiled first; 40 MHz core clock
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_params.svh"
module cpu_register_set_and_flags_tb import cpu_regs_pkg::*;;
    // ==========================================================================
    logic core_clk, rst, reg_wr, reg_rd, go, irq_pending, dp_data_wr, dp_wide_wr, dp_wide_hi;
    logic dp_addr_wr, dp_addr_idx, dp_addr_pair_wr, dp_pc_wr, dp_sp_wr, sw_trap_ack;
    logic [1:0] dp_data_idx;
    logic [2:0] irq_req_level;
    logic [3:0] reg_addr;
    logic [5:0] sw_trap_num;
    logic [15:0] dp_data_val, dp_addr_val, dp_sp_val, op_a, op_b;
    logic [19:0] dp_pc_val;
    logic [31:0] reg_wdata, dp_wide_val, dp_addr_pair_val, r, e;
    logic [31:0] v [16];
    lane_sel_t dp_data_lane = lane_word;
    int n_errors = 0;
    int n_tests = 0;
    wire logic [31:0] reg_rdata, wide_data_lo_pair, wide_data_hi_pair, wide_addr_pair;
    wire logic [15:0] active_stack_ptr, frame_base, static_base;
    wire logic [19:0] vector_table_base, next_instr_addr;
    wire logic [10:0] cpu_flags;
    wire logic [7:0] gp_data_0_high, gp_data_0_low;
    wire logic regset_select, irq_accept, alu_done, alu_carry, alu_zero, alu_neg, alu_ovf;
    wire logic hw_irq_ack;
    // free-running core clock
    always #12.5 core_clk = ~core_clk;
    cpu_register_set DUT (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .dp_data_wr, .dp_data_idx, .dp_data_lane, .dp_data_val, .dp_wide_wr, .dp_wide_hi,
        .dp_wide_val, .dp_addr_wr, .dp_addr_idx, .dp_addr_val, .dp_addr_pair_wr, .dp_addr_pair_val,
        .dp_pc_wr, .dp_pc_val, .dp_sp_wr, .dp_sp_val, .alu_done, .alu_carry, .alu_zero, .alu_neg,
        .alu_ovf, .hw_irq_ack, .sw_trap_ack, .sw_trap_num, .irq_req_level, .dp_rd_idx_unused_low(),
        .wide_data_lo_pair, .wide_data_hi_pair, .wide_addr_pair, .gp_data_0_high, .gp_data_0_low,
        .active_stack_ptr, .frame_base, .static_base, .vector_table_base, .next_instr_addr,
        .cpu_flags, .regset_select, .irq_accept);
    dp_partner u_partner (.core_clk, .rst, .go, .op_a, .op_b, .irq_pending, .irq_accept,
        .alu_done, .alu_carry, .alu_zero, .alu_neg, .alu_ovf, .hw_irq_ack);
    // ==========================================================================
    // compare, bus cycles, expectations and the closing verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    // read data stand from the cycle after the strobe until the next read, so look there
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata, exp);
    endtask
    function automatic logic [31:0] wmask(input int i);
        return (i == 7 || i == 8) ? 32'h000FFFFF : (i == 12) ? 32'h00000000 : 32'h0000FFFF;
    endfunction
    function automatic logic [31:0] alu_exp(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'h0, a} + {1'h0, b};
        alu_exp = 32'h0;
        alu_exp[`FLG_CARRY] = s[16];
        alu_exp[`FLG_ZERO] = s[15:0] == 16'h0000;
        alu_exp[`FLG_SIGN] = s[15];
        alu_exp[`FLG_WRAP] = a[15] == b[15] && s[15] != a[15];
    endfunction
    task automatic report_and_stop;
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end
    // ==========================================================================
    // main sequence
    initial begin
        {core_clk, reg_wr, reg_rd, go, irq_pending, dp_data_wr, dp_wide_wr, dp_wide_hi} = '0;
        {dp_addr_wr, dp_addr_idx, dp_addr_pair_wr, dp_pc_wr, dp_sp_wr, sw_trap_ack} = '0;
        {dp_data_idx, irq_req_level, reg_addr, sw_trap_num, dp_data_val, dp_addr_val} = '0;
        {dp_sp_val, op_a, op_b, dp_pc_val, reg_wdata, dp_wide_val, dp_addr_pair_val} = '0;
        rst = 1'h1;
        void'($urandom(32'h3156));
        repeat (5) @(posedge core_clk);
        rst <= 1'h0;
        for (int i = 0; i < 14; i++) rd(i[3:0], 32'h0);
        // random contents, flags kept clear, unmapped places written too
        for (int i = 0; i < 16; i++) begin
            v[i] = $urandom & wmask(i);
            if (i != 13) wr(i[3:0], v[i]);
        end
        for (int i = 0; i < 13; i++) rd(i[3:0], v[i]);
        rd(4'hE, 32'h0);
        rd(4'hF, 32'h0);
        chk(wide_data_lo_pair, {v[2][15:0], v[0][15:0]});
        chk(wide_data_hi_pair, {v[3][15:0], v[1][15:0]});
        chk(wide_addr_pair, {v[5][15:0], v[4][15:0]});
        chk({gp_data_0_high, gp_data_0_low}, v[0]);
        chk(frame_base, v[6]);
        chk(static_base, v[11]);
        chk(vector_table_base, v[7]);
        chk(active_stack_ptr, v[10]);
        // stack and bank select; the trace bit is never set
        wr(`IDX_CPU_FLAGS, 32'h080);
        rd(`IDX_ACTIVE_SP, v[9]);
        wr(`IDX_CPU_FLAGS, 32'h010);
        rd(`IDX_GP_DATA_0, 32'h0);
        wr(`IDX_GP_DATA_0, 32'h00005AA5);
        rd(`IDX_GP_DATA_0, 32'h00005AA5);
        wr(`IDX_CPU_FLAGS, 32'h0);
        rd(`IDX_GP_DATA_0, v[0]);
        // byte lanes of the first data register from the datapath
        e = v[0];
        for (int k = 0; k < 3; k++) begin
            r = $urandom;
            @(posedge core_clk);
            dp_data_wr <= 1'h1;
            dp_data_lane <= lane_sel_t'(k);
            dp_data_val <= r[15:0];
            @(posedge core_clk);
            dp_data_wr <= 1'h0;
            if (k == 0) e[15:0] = r[15:0];
            else if (k == 1) e[7:0] = r[7:0];
            else e[15:8] = r[7:0];
            #1 chk({gp_data_0_high, gp_data_0_low}, e);
        end
        // wide pair, address pair, pc and stack pointer in one cycle
        r = $urandom;
        @(posedge core_clk);
        {dp_wide_wr, dp_addr_pair_wr, dp_pc_wr, dp_sp_wr, dp_wide_hi} <= {4'hF, r[0]};
        {dp_wide_val, dp_addr_pair_val, dp_pc_val, dp_sp_val} <= {r, ~r, r[19:0], r[31:16]};
        @(posedge core_clk);
        {dp_wide_wr, dp_addr_pair_wr, dp_pc_wr, dp_sp_wr} <= 4'h0;
        #1 chk(r[0] ? wide_data_hi_pair : wide_data_lo_pair, r);
        chk(wide_addr_pair, ~r);
        chk(next_instr_addr, r[19:0]);
        chk(active_stack_ptr, r[31:16]);
        // alu results: overflow, zero and sign corners, then random operands
        for (int i = 0; i < 12; i++) begin
            r = (i == 0) ? 32'h80008000 : (i == 1) ? 32'h0001FFFF : (i == 2) ? 32'h7FFF0001 : $urandom;
            @(posedge core_clk);
            {go, op_a, op_b} <= {1'h1, r};
            @(posedge core_clk);
            go <= 1'h0;
            @(posedge core_clk);
            #1 chk(cpu_flags, alu_exp(r[31:16], r[15:0]));
        end
        // every request level against priority 3 with the gate open, then level 7 with the gate shut
        wr(`IDX_CPU_FLAGS, 32'h3C0);
        for (int l = 0; l < 8; l++) begin
            @(posedge core_clk);
            irq_req_level <= l[2:0];
            #1 chk(irq_accept, l > 3);
        end
        wr(`IDX_CPU_FLAGS, 32'h380);
        #1 chk(irq_accept, 1'h0);
        // hardware acknowledge through the partner
        wr(`IDX_CPU_FLAGS, 32'h3C0);
        irq_pending <= 1'h1;
        repeat (3) @(posedge core_clk);
        irq_pending <= 1'h0;
        #1 chk(cpu_flags, 32'h300);
        // traps at the top of the low range and just above it
        for (int t = 31; t < 33; t++) begin
            wr(`IDX_CPU_FLAGS, 32'h3C0);
            sw_trap_ack <= 1'h1;
            sw_trap_num <= t[5:0];
            @(posedge core_clk);
            sw_trap_ack <= 1'h0;
            #1 chk(cpu_flags, (t == 31) ? 32'h300 : 32'h380);
        end
        // single datapath writes, each data register write against a software write to the same register
        dp_data_lane <= lane_word;
        for (int k = 0; k < 4; k++) begin
            r = $urandom;
            @(posedge core_clk);
            {dp_addr_wr, dp_addr_idx, dp_addr_val} <= {1'h1, k[0], r[15:0]};
            {dp_data_wr, dp_data_idx, dp_data_val} <= {1'h1, k[1:0], r[31:16]};
            {reg_wr, reg_addr, reg_wdata} <= {3'h4, k[1:0], ~r};
            @(posedge core_clk);
            {dp_addr_wr, dp_data_wr, reg_wr} <= 3'h0;
            #1 chk(k[0] ? wide_addr_pair[31:16] : wide_addr_pair[15:0], r[15:0]);
            rd(k[1:0], r[31:16]);
        end
        report_and_stop();
    end
endmodule // cpu_register_set_and_flags_tb
`default_nettype wire
